/* core/stirb_consts.svh */
// Offsets, field positions and reset values of the status readback window
`ifndef STIRB_CONSTS_SVH
`define STIRB_CONSTS_SVH

`define STIRB_ADDR_CTRL    4'he
`define STIRB_ADDR_STAT    4'hf
`define STIRB_SEL_RESET    4'h0
`define STIRB_SEL_MSB      3
`define STIRB_BIT_ALOS     7
`define STIRB_BIT_DLOS     6
`define STIRB_BIT_TXCLK    5
`define STIRB_BIT_OOF      4
`define STIRB_BIT_RXLOCK   1
`define STIRB_BIT_CODEERR  0
`define STIRB_LATCH_RESET  8'h00

`endif

/* core/stirb_pkg.sv */
// Types of the status readback window
package stirb_pkg;

   typedef enum logic [3:0] {
      STIRB_VIEW_LIVE = 4'h0,
      STIRB_VIEW_INT  = 4'h5,
      STIRB_VIEW_ID   = 4'h6
   } stirb_view_type;

endpackage : stirb_pkg

/* core/stirb_event_latch.sv */
// Sticky event bits with per-bit clear, set winning over clear
`timescale 1ns/1ps
module stirb_event_latch
   import stirb_pkg::*;
#(
   parameter int WIDTH = 8
) (
   // Clock and reset
   input  wire logic             sys_clk,
   input  wire logic             reset,
   // Events and clears
   input  wire logic [WIDTH-1:0] set_vec,
   input  wire logic [WIDTH-1:0] clear_vec,
   // Latched state
   output logic      [WIDTH-1:0] held
);

   // A new event in the clearing cycle must survive
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         held <= '0;
      end else begin
         held <= (held & ~clear_vec) | set_vec;
      end
   end

   ////////////////////////////////////////////////////////////////////////////

   chk_set_wins: assert property (
      @(posedge sys_clk) disable iff (reset)
      (held & $past(set_vec)) == $past(set_vec))
      else $error("event lost against clear");

   chk_sticky_hold: assert property (
      @(posedge sys_clk) disable iff (reset)
      ($past(held) & ~$past(clear_vec) & ~held) == '0)
      else $error("latched bit dropped without clear");

endmodule : stirb_event_latch

/* core/stirb_readback.sv */
// Status readback window at control address 15 with view selector at 14
`timescale 1ns/1ps
`include "stirb_consts.svh"
module stirb_readback
   import stirb_pkg::*;
#(
   // Arbitrary revision value
   parameter logic [7:0] REVISION = 8'h01
) (
   // Clock and reset
   input  wire logic       sys_clk,
   input  wire logic       reset,
   // Register access from the serial control port
   input  wire logic [3:0] reg_addr,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   input  wire logic [7:0] reg_wdata,
   output logic      [7:0] reg_rdata,
   output logic            reg_rvalid,
   // Alarm sources
   input  wire logic       alarm_ana_los,
   input  wire logic       alarm_dig_los,
   input  wire logic       alarm_tx_clk,
   input  wire logic       alarm_oof,
   input  wire logic       alarm_rx_lock,
   input  wire logic       alarm_code_err
);

   logic [3:0] view_sel;
   logic [7:0] live;
   logic [7:0] latch_set;
   logic [7:0] latch_clr;
   logic [7:0] latched;
   logic       rd_stat;
   logic       rd_ctrl;
   logic [7:0] next_rdata;

   // Alarm levels placed in their status bit positions; unused bits zero
   function automatic logic [7:0] alarm_byte(input logic ana, input logic dig,
                                             input logic txc, input logic oof,
                                             input logic rxl);
      logic [7:0] b;
      b                    = 8'h00;
      b[`STIRB_BIT_ALOS]   = ana;
      b[`STIRB_BIT_DLOS]   = dig;
      b[`STIRB_BIT_TXCLK]  = txc;
      b[`STIRB_BIT_OOF]    = oof;
      b[`STIRB_BIT_RXLOCK] = rxl;
      return b;
   endfunction : alarm_byte

   ////////////////////////////////////////////////////////////////////////////

   assign live    = alarm_byte(alarm_ana_los, alarm_dig_los, alarm_tx_clk,
                               alarm_oof, alarm_rx_lock);
   assign rd_stat = reg_rd && (reg_addr == `STIRB_ADDR_STAT);
   assign rd_ctrl = reg_rd && (reg_addr == `STIRB_ADDR_CTRL);

   // Selector write; address 15 has no write path
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         view_sel <= `STIRB_SEL_RESET;
      end else if (reg_wr && (reg_addr == `STIRB_ADDR_CTRL)) begin
         view_sel <= reg_wdata[`STIRB_SEL_MSB:0];
      end
   end

   always_comb begin
      latch_set = live;
      latch_set[`STIRB_BIT_CODEERR] = alarm_code_err;
      latch_clr = 8'h00;
      if (rd_stat && (view_sel == STIRB_VIEW_LIVE)) begin
         latch_clr[7:1] = 7'h7f;
      end else if (rd_stat && (view_sel == STIRB_VIEW_INT)) begin
         latch_clr[`STIRB_BIT_CODEERR] = 1'b1;
      end
   end

   stirb_event_latch #(
      .WIDTH     (8)
   ) u_latch (
      .sys_clk   (sys_clk),
      .reset     (reset),
      .set_vec   (latch_set),
      .clear_vec (latch_clr),
      .held      (latched)
   );

   // Reserved selectors read as zero
   always_comb begin
      next_rdata = 8'h00;
      if (rd_ctrl) begin
         next_rdata = {4'h0, view_sel};
      end else if (rd_stat) begin
         case (view_sel)
            STIRB_VIEW_LIVE: next_rdata = live;
            STIRB_VIEW_INT:  next_rdata = latched;
            STIRB_VIEW_ID:   next_rdata = REVISION;
            default:         next_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         reg_rdata <= 8'h00;
      end else if (rd_ctrl || rd_stat) begin
         reg_rdata <= next_rdata;
      end
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= rd_ctrl || rd_stat;
      end
   end

   ////////////////////////////////////////////////////////////////////////////

   chk_live_view: assert property (
      @(posedge sys_clk) disable iff (reset)
      (rd_stat && view_sel == 4'h0) |=> reg_rvalid &&
      reg_rdata == {$past(alarm_ana_los), $past(alarm_dig_los), $past(alarm_tx_clk),
                    $past(alarm_oof), 2'b00, $past(alarm_rx_lock), 1'b0})
      else $error("live view byte wrong");

   chk_int_view: assert property (
      @(posedge sys_clk) disable iff (reset)
      (rd_stat && view_sel == 4'h5) |=> reg_rdata == $past(latched))
      else $error("interrupt view byte wrong");

   chk_id_view: assert property (
      @(posedge sys_clk) disable iff (reset)
      (rd_stat && view_sel == 4'h6) |=> reg_rdata == REVISION)
      else $error("revision byte wrong");

   chk_clear_status: assert property (
      @(posedge sys_clk) disable iff (reset)
      (rd_stat && view_sel == 4'h0) |=>
      latched[7:1] == $past(latch_set[7:1]) &&
      latched[0] == ($past(latched[0]) | $past(alarm_code_err)))
      else $error("status read clear wrong");

   chk_clear_coding: assert property (
      @(posedge sys_clk) disable iff (reset)
      (rd_stat && view_sel == 4'h5) |=>
      latched[0] == $past(alarm_code_err) &&
      latched[7:1] == ($past(latched[7:1]) | $past(latch_set[7:1])))
      else $error("coding error clear wrong");

   chk_sel_write: assert property (
      @(posedge sys_clk) disable iff (reset)
      (reg_wr && reg_addr == 4'he) |=> view_sel == $past(reg_wdata[3:0]))
      else $error("selector write lost");

   chk_stat_readonly: assert property (
      @(posedge sys_clk) disable iff (reset)
      (reg_wr && reg_addr == 4'hf) |=> $stable(view_sel) && latched ==
      (($past(latched) & ~$past(latch_clr)) | $past(latch_set)))
      else $error("write to status window had effect");

   chk_reserved_zero: assert property (
      @(posedge sys_clk) disable iff (reset)
      (rd_stat && !(view_sel inside {4'h0, 4'h5, 4'h6})) |=>
      reg_rvalid && reg_rdata == 8'h00)
      else $error("reserved view not zero");

   // One answer per accepted read, none for refused addresses or writes
   chk_answer_pulse: assert property (
      @(posedge sys_clk) disable iff (reset)
      !$past(reset) |-> reg_rvalid == $past(rd_ctrl || rd_stat))
      else $error("read answer pulse wrong");

   // Host may pick the byte up late, so it must hold between reads
   chk_rdata_hold: assert property (
      @(posedge sys_clk) disable iff (reset)
      (!$past(reset) && !$past(rd_ctrl || rd_stat)) |-> $stable(reg_rdata))
      else $error("read byte changed without a read");

   chk_ctrl_readback: assert property (
      @(posedge sys_clk) disable iff (reset)
      rd_ctrl |=> reg_rvalid && reg_rdata == {4'h0, $past(view_sel)})
      else $error("selector readback wrong");

   chk_sel_keep: assert property (
      @(posedge sys_clk) disable iff (reset)
      !(reg_wr && reg_addr == 4'he) |=> $stable(view_sel))
      else $error("selector changed without a write");

   // Events arriving during a clearing read must not be lost
   chk_code_sticky: assert property (
      @(posedge sys_clk) disable iff (reset)
      alarm_code_err |=> latched[0])
      else $error("coding error event lost");

   chk_alarm_sticky: assert property (
      @(posedge sys_clk) disable iff (reset)
      (live != 8'h00) |=> (latched & $past(live)) == $past(live))
      else $error("alarm event lost");

   // Unused positions of the interrupt view carry no alarm
   chk_int_unused: assert property (
      @(posedge sys_clk) disable iff (reset)
      (rd_stat && view_sel == 4'h5) |=> reg_rdata[3:2] == 2'b00)
      else $error("unused interrupt bits set");

endmodule : stirb_readback

/* tb/stirb_host.sv */
// Host model issuing register reads and writes
`timescale 1ns/1ps
module stirb_host (
   // Clock
   input  wire logic       sys_clk,
   // Register access
   output logic      [3:0] reg_addr,
   output logic            reg_wr,
   output logic            reg_rd,
   output logic      [7:0] reg_wdata
);
   initial begin
      reg_addr = 4'h0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_wdata = 8'h00;
   end
   // Selector set to reserved view 9 once, never to reserved views 1 to 4
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      reg_wdata <= ~d;
   endtask : wr
   task automatic rd(input logic [3:0] a);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
   endtask : rd
endmodule : stirb_host

/* tb/test_status_interrupt_readback.sv */
// Self-checking bench of the status readback window
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_fail++; \
   $display("mismatch at %0t: read byte differs", $time); end end
module test_status_interrupt_readback;
   logic       sys_clk = 1'b0;
   logic       reset = 1'b1;
   logic [3:0] reg_addr;
   logic       reg_wr, reg_rd;
   logic [7:0] reg_wdata, reg_rdata;
   logic       reg_rvalid;
   logic [5:0] al = 6'h00;
   logic [7:0] exp_q[$], msk_q[$];
   int         n_fail = 0;
   int         n_tests = 0;
   stirb_readback #(.REVISION(8'h3c)) stirb_readback_inst (.sys_clk(sys_clk), .reset(reset),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .alarm_ana_los(al[5]),
      .alarm_dig_los(al[4]), .alarm_tx_clk(al[3]), .alarm_oof(al[2]),
      .alarm_rx_lock(al[1]), .alarm_code_err(al[0]));
   stirb_host stirb_host_inst (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_wdata(reg_wdata));
   initial forever #12.5 sys_clk = ~sys_clk;
   task automatic wrap_up;
      if (n_fail == 0 && n_tests > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : wrap_up
   // Note expected byte and care mask, then issue the read
   task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
      exp_q.push_back(e & m);
      msk_q.push_back(m);
      stirb_host_inst.rd(a);
   endtask : rd
   function automatic logic [7:0] vw(input logic [5:0] v);
      return {v[5:2], 2'b00, v[1:0]};
   endfunction : vw
   ////////////////////////////////////////////////////////////////////////////
   // Sampled mid-cycle so the answer register has settled
   always @(negedge sys_clk) begin
      if (reg_rvalid === 1'b1) begin
         if (exp_q.size() == 0) `CHK(1'b1, 1'b0)
         else `CHK(reg_rdata & msk_q.pop_front(), exp_q.pop_front())
      end
   end
   initial begin
      #(25 * 4000);
      n_fail++;
      wrap_up();
   end
   initial begin
      logic [5:0] v;
      void'($urandom(65087));
      repeat (12) @(posedge sys_clk);
      reset <= 1'b0;
      rd(4'he, 8'h00, 8'h0f);
      stirb_host_inst.wr(4'he, 8'h06);
      stirb_host_inst.wr(4'hf, 8'h5a);
      rd(4'hf, 8'h3c, 8'hff);
      stirb_host_inst.rd(4'h3);
      @(negedge sys_clk);
      `CHK(reg_rvalid, 1'b0)
      `CHK(reg_rdata, 8'h3c)
      stirb_host_inst.wr(4'he, 8'h09);
      rd(4'he, 8'h09, 8'h0f);
      rd(4'hf, 8'h00, 8'hff);
      for (int i = 0; i < 8; i++) begin
         v = 6'($urandom);
         @(posedge sys_clk);
         al <= v;
         @(posedge sys_clk);
         al <= {v[5:1], 1'b0};
         @(posedge sys_clk);
         al <= 6'h00;
         stirb_host_inst.wr(4'he, 8'h05);
         rd(4'hf, vw(v), 8'hf3);
         rd(4'hf, vw({v[5:1], 1'b0}), 8'hf3);
         stirb_host_inst.wr(4'he, 8'h00);
         rd(4'hf, 8'h00, 8'hf2);
         stirb_host_inst.wr(4'he, 8'h05);
         rd(4'hf, 8'h00, 8'hf3);
         stirb_host_inst.wr(4'he, 8'h00);
         @(posedge sys_clk);
         al <= {v[5:1], 1'b0};
         rd(4'hf, vw(v), 8'hf2);
         al <= 6'h00;
         rd(4'hf, 8'h00, 8'hf2);
      end
      repeat (4) @(posedge sys_clk);
      `CHK(exp_q.size(), 0)
      wrap_up();
   end
endmodule : test_status_interrupt_readback
